/* pkg/ssr_map.vh */
`ifndef SSR_MAP_VH
`define SSR_MAP_VH
// ==========================================
// register byte offsets
`define SSR_OFF_CTRL 12'h000
`define SSR_OFF_STAT 12'h004
`define SSR_OFF_DATA 12'h008
`define SSR_OFF_IRQ_STAT 12'h00C
`define SSR_OFF_IRQ_EN 12'h010
`define SSR_OFF_IRQ_CLR 12'h014
// ==========================================
// control register fields
`define SSR_CTRL_SERIAL_PORT_ENABLE 0
`define SSR_CTRL_SINGLE_RECEIVE_ENABLE 1
`define SSR_CTRL_CONTINUOUS_RECEIVE_ENABLE 2
`define SSR_CTRL_RX9 3
// ==========================================
// status register fields
`define SSR_STAT_OVERRUN_ERROR_FLAG 0
`define SSR_STAT_NINTH_DATA_BIT 1
`define SSR_STAT_COUNT_LO 2
`define SSR_STAT_COUNT_HI 3
// ==========================================
// interrupt bits
`define SSR_IRQ_RX 0
`define SSR_IRQ_OVR 1
`define SSR_IRQ_W 2
// ==========================================
// sizes and reset values
`define SSR_CHAR_W 9
`define SSR_FIFO_DEPTH 2
`define SSR_BITS_8 4'h8
`define SSR_BITS_9 4'h9
`define SSR_ZERO32 32'h00000000
`endif

/* rtl/ssr_sync.v */
`timescale 1ns/1ps
// ==========================================
// two flip-flop level synchroniser
module ssr_sync (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // level in and out
  input wire async_in,
  output reg sync_out
);
  reg meta; // first stage, read only by sync_out

  // first stage is read by the second stage alone
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // ssr_sync

/* rtl/ssr_fifo.v */
`timescale 1ns/1ps
`include "ssr_map.vh"
// ==========================================
// two-entry receive queue for nine-bit characters
module ssr_fifo (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // synchronous flush from the port enable
  input wire flush,
  // write side
  input wire push,
  input wire [`SSR_CHAR_W-1:0] push_data,
  // read side
  input wire pop,
  output wire [`SSR_CHAR_W-1:0] head,
  output reg [1:0] count
);
  reg [`SSR_CHAR_W-1:0] mem [0:`SSR_FIFO_DEPTH-1]; // storage slots
  reg wr_ptr; // next slot to fill
  reg rd_ptr; // oldest slot
  wire do_push;
  wire do_pop;

  // never overwrite: pushes into a full queue are dropped here as well
  assign do_push = push && (count != 2'h2);
  assign do_pop = pop && (count != 2'h0);
  assign head = mem[rd_ptr];

  // pointers and occupancy
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_push && !do_pop) begin
        count <= count + 2'h1;
      end else if (do_pop && !do_push) begin
        count <= count - 2'h1;
      end
    end
  end

  // storage has no reset; contents are unread until pushed
  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
endmodule // ssr_fifo

/* rtl/ssr_rx.v */
`timescale 1ns/1ps
`include "ssr_map.vh"
// Behaviour
// RULE1 - slave mode: clock pin driver off, clock input
// RULE2 - data stable at trailing clock edge, sampled there
// RULE3 - one bit shifted per received clock cycle
// RULE4 - master sends only as many clocks as bits
// RULE5 - receive queue holds two whole characters
// RULE6 - third character into full queue sets overrun
// RULE7 - on overrun keep queue, drop new character
// RULE8 - no characters accepted while overrun pending
// RULE9 - overrun flag not software writable
// RULE10 - single-receive overrun clears on data read
// RULE11 - continuous overrun clears on enable clear
// RULE12 - port enable clear resets whole receiver
// RULE13 - nine-bit mode shifts nine bits per character
// RULE14 - ninth bit shows oldest unread character
// RULE15 - software reads ninth bit before data
// RULE16 - character complete sets flag, interrupt if enabled
// RULE17 - data read pops oldest character
module ssr_rx (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // shared transmit/clock pin
  input wire transmit_clock_pin_in,
  output reg transmit_clock_pin_out,
  output reg transmit_clock_pin_oe,
  // serial data pin
  input wire rx_data_pin,
  // interrupt
  output reg irq
);
  // ==========================================
  // declarations
  reg serial_port_enable; // port enable
  reg single_receive_enable; // single receive
  reg continuous_receive_enable; // continuous receive
  reg nine_bit_receive_select; // nine-bit characters
  reg overrun_error_flag; // sticky overrun
  reg ovr_single; // overrun arose in single-receive mode
  reg [`SSR_IRQ_W-1:0] irq_stat; // sticky events
  reg [`SSR_IRQ_W-1:0] irq_en; // event enables
  reg [`SSR_CHAR_W-1:0] receive_shift_register; // incoming bits
  reg [3:0] bit_cnt; // bits held in shift register
  reg clk_prev; // last synchronised clock level
  wire clk_s; // synchronised clock pin
  wire dat_s; // synchronised data pin
  wire clk_fall; // trailing edge of the link clock
  wire rx_enabled;
  wire [3:0] char_bits;
  wire char_done;
  wire push;
  wire [`SSR_CHAR_W-1:0] head;
  wire [1:0] count;
  wire acc;
  wire wr;
  wire rd;
  wire data_rd;
  wire ctrl_wr;
  wire flush;
  wire [`SSR_CHAR_W-1:0] next_char;

  // ==========================================
  // address check helper used by both read and write decode
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `SSR_OFF_CTRL) || (a == `SSR_OFF_STAT) ||
        (a == `SSR_OFF_DATA) || (a == `SSR_OFF_IRQ_STAT) ||
        (a == `SSR_OFF_IRQ_EN) || (a == `SSR_OFF_IRQ_CLR);
    end
  endfunction

  // ==========================================
  // pin synchronisers
  ssr_sync u_sync_clk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(transmit_clock_pin_in),
    .sync_out(clk_s)
  );

  ssr_sync u_sync_dat (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(rx_data_pin),
    .sync_out(dat_s)
  );

  // ==========================================
  // bus strobes: one-cycle wait so every access answers in the access phase
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && is_mapped(paddr);
  assign rd = acc && !pwrite && is_mapped(paddr);
  assign data_rd = rd && (paddr == `SSR_OFF_DATA);
  assign ctrl_wr = wr && (paddr == `SSR_OFF_CTRL);
  // clearing the port enable flushes every piece of receive state
  assign flush = !serial_port_enable; // [RULE12]

  // ==========================================
  // link clock edge finding
  // data changed on the rising edge, so the falling edge samples it
  assign clk_fall = clk_prev && !clk_s; // [RULE2]
  assign rx_enabled = serial_port_enable &&
    (single_receive_enable || continuous_receive_enable);
  assign char_bits = nine_bit_receive_select ? `SSR_BITS_9 : `SSR_BITS_8; // [RULE13]
  assign char_done = clk_fall && rx_enabled && (bit_cnt == char_bits - 4'h1);
  // lsb first; the last bit lands on top, the eight-bit case is realigned
  assign next_char = nine_bit_receive_select ?
    {dat_s, receive_shift_register[`SSR_CHAR_W-1:1]} :
    {1'b0, dat_s, receive_shift_register[`SSR_CHAR_W-1:2]};
  // overrun blocks the queue until cleared
  assign push = char_done && !overrun_error_flag && (count != 2'h2); // [RULE8]

  // ==========================================
  // receive queue
  ssr_fifo u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(flush),
    .push(push),
    .push_data(next_char),
    .pop(data_rd), // [RULE17]
    .head(head),
    .count(count)
  );

  // ==========================================
  // pin driver: slave never drives the shared clock pin
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe <= 1'b0;
    end else begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe <= 1'b0; // [RULE1]
    end
  end

  // ==========================================
  // shift register, one bit per trailing edge
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_prev <= 1'b0;
      receive_shift_register <= {`SSR_CHAR_W{1'b0}};
      bit_cnt <= 4'h0;
    end else begin
      clk_prev <= clk_s;
      if (flush || !rx_enabled) begin
        receive_shift_register <= {`SSR_CHAR_W{1'b0}}; // [RULE12]
        bit_cnt <= 4'h0;
      end else if (clk_fall) begin
        receive_shift_register <= {dat_s, receive_shift_register[`SSR_CHAR_W-1:1]}; // [RULE3]
        // extra clocks beyond a character start a new one
        if (char_done) begin
          bit_cnt <= 4'h0;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // ==========================================
  // control register and overrun tracking
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_port_enable <= 1'b0;
      single_receive_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
      nine_bit_receive_select <= 1'b0;
      overrun_error_flag <= 1'b0;
      ovr_single <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        serial_port_enable <= pwdata[`SSR_CTRL_SERIAL_PORT_ENABLE];
        single_receive_enable <= pwdata[`SSR_CTRL_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable <= pwdata[`SSR_CTRL_CONTINUOUS_RECEIVE_ENABLE];
        nine_bit_receive_select <= pwdata[`SSR_CTRL_RX9];
      end else if (single_receive_enable && !continuous_receive_enable && push) begin
        // single receive ends after one character is queued while continuous receive is off, unless a control write lands in that cycle
        single_receive_enable <= 1'b0;
      end
      // the flag is written only here, never from the bus
      if (flush) begin
        overrun_error_flag <= 1'b0; // [RULE9] [RULE11]
      end else if (char_done && !overrun_error_flag && count == 2'h2) begin
        overrun_error_flag <= 1'b1; // [RULE6] [RULE7]
        ovr_single <= !continuous_receive_enable;
      end else if (overrun_error_flag && ovr_single && data_rd) begin
        overrun_error_flag <= 1'b0; // [RULE10]
      end else if (overrun_error_flag && !ovr_single && ctrl_wr &&
                   !pwdata[`SSR_CTRL_CONTINUOUS_RECEIVE_ENABLE]) begin
        overrun_error_flag <= 1'b0; // [RULE11]
      end
    end
  end

  // ==========================================
  // interrupt status, enable and write-one-to-clear; set beats clear
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= {`SSR_IRQ_W{1'b0}};
      irq_en <= {`SSR_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `SSR_OFF_IRQ_EN) begin
        irq_en <= pwdata[`SSR_IRQ_W-1:0];
      end
      if (flush) begin
        irq_stat <= {`SSR_IRQ_W{1'b0}};
      end else begin
        irq_stat[`SSR_IRQ_RX] <= push || (irq_stat[`SSR_IRQ_RX] &&
          !(wr && paddr == `SSR_OFF_IRQ_CLR && pwdata[`SSR_IRQ_RX])); // [RULE16]
        irq_stat[`SSR_IRQ_OVR] <= (char_done && !overrun_error_flag &&
          count == 2'h2) || (irq_stat[`SSR_IRQ_OVR] &&
          !(wr && paddr == `SSR_OFF_IRQ_CLR && pwdata[`SSR_IRQ_OVR]));
      end
      irq <= |(irq_stat & irq_en); // [RULE16]
    end
  end

  // ==========================================
  // apb answer: one wait state, then ready with data
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `SSR_ZERO32;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
      prdata <= `SSR_ZERO32;
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == `SSR_OFF_CTRL) begin
          prdata[`SSR_CTRL_SERIAL_PORT_ENABLE] <= serial_port_enable;
          prdata[`SSR_CTRL_SINGLE_RECEIVE_ENABLE] <= single_receive_enable;
          prdata[`SSR_CTRL_CONTINUOUS_RECEIVE_ENABLE] <= continuous_receive_enable;
          prdata[`SSR_CTRL_RX9] <= nine_bit_receive_select;
        end else if (paddr == `SSR_OFF_STAT) begin
          prdata[`SSR_STAT_OVERRUN_ERROR_FLAG] <= overrun_error_flag;
          // an empty queue shows no ninth bit; its slots hold stale or unset data
          prdata[`SSR_STAT_NINTH_DATA_BIT] <= (count != 2'h0) && head[`SSR_CHAR_W-1]; // [RULE14]
          prdata[`SSR_STAT_COUNT_HI:`SSR_STAT_COUNT_LO] <= count; // [RULE5]
        end else if (paddr == `SSR_OFF_DATA) begin
          prdata[7:0] <= (count != 2'h0) ? head[7:0] : 8'h00;
        end else if (paddr == `SSR_OFF_IRQ_STAT) begin
          prdata[`SSR_IRQ_W-1:0] <= irq_stat;
        end else if (paddr == `SSR_OFF_IRQ_EN) begin
          prdata[`SSR_IRQ_W-1:0] <= irq_en;
        end
      end
    end
  end
endmodule // ssr_rx

/* test/ssr_rx_checker.sv */
`timescale 1ns/1ps
// ==========================================
// port-level checker for the receiver
module ssr_rx_checker (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins
  input wire transmit_clock_pin_in,
  input wire transmit_clock_pin_out,
  input wire transmit_clock_pin_oe,
  input wire rx_data_pin,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // completed transfer and status read
  wire take = psel && penable && pready;
  wire st_rd = take && !pwrite && (paddr == 12'h004);
  reg port_off; // enable bit last written as 0
  reg [1:0] en_sh; // shadow of the interrupt enables
  // shadows follow writes at the taking edge
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_off <= 1'b1;
      en_sh <= 2'h0;
    end else if (take && pwrite) begin
      if (paddr == 12'h000) begin
        port_off <= !pwdata[0];
      end
      if (paddr == 12'h010) begin
        en_sh <= pwdata[1:0];
      end
    end
  end
  // ==========================================
  // assertions
  property p_pin_off; !transmit_clock_pin_oe && !transmit_clock_pin_out; endproperty
  a_pin_off: assert property (p_pin_off) else $error("clock pin driven");
  property p_ready_lat; psel && $rose(penable) |=> pready; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("late ready");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("long ready");
  property p_err_map; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014); endproperty
  a_err_map: assert property (p_err_map) else $error("bad slave error");
  property p_count; st_rd |-> prdata[3:2] != 2'h3 && prdata[31:4] == 28'h0; endproperty
  a_count: assert property (p_count) else $error("queue count");
  property p_off_clr;
    take && !pwrite && port_off && (paddr == 12'h004 || paddr == 12'h00C) |-> prdata == 32'h0;
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("state kept off");
  property p_irq_off; port_off && $past(port_off, 3) |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while off");
  property p_irq_en; en_sh == 2'h0 && $past(en_sh == 2'h0, 2) |-> !irq; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq not enabled");
endmodule // ssr_rx_checker
bind ssr_rx ssr_rx_checker i_chk (.*);

/* test/ssr_master.sv */
`timescale 1ns/1ps
// ==========================================
// external master: makes the shift clock and data
module ssr_master (
  // link pins
  output reg sck,
  output reg sd
);
  // clock stands low between frames
  initial begin
    sck = 1'b0;
    sd = 1'b1;
  end
  // one frame, lsb first, 160 ns per bit
  task send(input [8:0] ch, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin // one pulse per bit, none extra
        #80;
        sck = 1'b1;
        sd = ch[i]; // data moves on the leading edge
        #80;
        sck = 1'b0; // trailing edge finds it stable
      end
      #80;
      sd = ~sd; // hold over: line stops showing the last bit
    end
  endtask
endmodule // ssr_master

/* test/tb_sync_serial_slave_receiver.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
  fails = fails + 1; $display("mismatch %0t %h %h", $time, a, e); end end
// ==========================================
// bench top
module tb_sync_serial_slave_receiver;
  reg sys_clk, resetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, ck_out, ck_oe, irq, sck, sd;
  integer fails, checked, i;
  ssr_rx i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_clock_pin_in(sck), .transmit_clock_pin_out(ck_out),
    .transmit_clock_pin_oe(ck_oe), .rx_data_pin(sd), .irq(irq));
  ssr_master i_mst (.sck(sck), .sd(sd));
  // 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task test_done;
    begin
      if (fails == 0 && checked > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // one apb transfer; waits for ready under a bound
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
        fails = fails + 1;
        test_done;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
    end
  endtask
  // ==========================================
  // scenarios
  task t_regs;
    begin
      apb(1'b1, 12'h004, 32'hF);
      rchk(12'h004, 32'h0);
      rchk(12'h018, 32'h0);
      `CHK(er, 1'b1)
      `CHK(ck_oe, 1'b0)
    end
  endtask
  task t_basic;
    begin
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h000, 32'h5);
      i_mst.send(9'h0A5, 8);
      @(posedge sys_clk);
      `CHK(irq, 1'b1)
      rchk(12'h00C, 32'h1);
      rchk(12'h004, 32'h4);
      rchk(12'h008, 32'hA5);
      apb(1'b1, 12'h014, 32'h3);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h000, 32'h0);
    end
  endtask
  task t_cont;
    begin
      apb(1'b1, 12'h000, 32'h5);
      for (i = 1; i < 4; i = i + 1) i_mst.send(9'h011 * i, 8);
      rchk(12'h004, 32'h9);
      rchk(12'h00C, 32'h3);
      rchk(12'h008, 32'h11);
      i_mst.send(9'h044, 8);
      rchk(12'h004, 32'h5);
      apb(1'b1, 12'h000, 32'h1);
      rchk(12'h004, 32'h4);
      rchk(12'h008, 32'h22);
      rchk(12'h008, 32'h0);
      apb(1'b1, 12'h000, 32'h0);
    end
  endtask
  task t_single;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        apb(1'b1, 12'h000, 32'h3);
        i_mst.send(9'h060 + i, 8);
      end
      rchk(12'h004, 32'h9);
      rchk(12'h008, 32'h60);
      rchk(12'h004, 32'h4);
      apb(1'b1, 12'h000, 32'h0);
    end
  endtask
  task t_nine;
    begin
      apb(1'b1, 12'h000, 32'hD);
      i_mst.send(9'h1A5, 9);
      i_mst.send(9'h03C, 9);
      rchk(12'h004, 32'hA);
      rchk(12'h008, 32'hA5);
      rchk(12'h004, 32'h4);
      rchk(12'h008, 32'h3C);
    end
  endtask
  task t_off;
    begin
      apb(1'b1, 12'h000, 32'h5);
      i_mst.send(9'h05A, 8);
      apb(1'b1, 12'h000, 32'h0);
      repeat (4) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h000, 32'h5);
      rchk(12'h004, 32'h0);
      rchk(12'h008, 32'h0);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    fails = 0;
    checked = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs;
    t_basic;
    t_cont;
    t_single;
    t_nine;
    t_off;
    test_done;
  end
endmodule // tb_sync_serial_slave_receiver
